/* design/sett_pkg.sv */
package sett_pkg;
  // ==========================================
  // Register map
  localparam logic [11:0] OFF_SYNC_CTRL = 12'h0D4;
  localparam logic [11:0] OFF_CMD = 12'h100;
  localparam logic [11:0] OFF_BLK_LVL = 12'h1C0;
  localparam logic [11:0] OFF_STATUS = 12'h1C4;
  localparam logic [11:0] OFF_LUT_ADDR = 12'h1C8;
  localparam logic [11:0] OFF_LUT_DATA = 12'h1CC;
  localparam logic [11:0] OFF_EVT_NUM = 12'h1D0;
  localparam logic [11:0] OFF_TRG_TIME = 12'h1D4;
  // ==========================================
  // Fields and reset values
  localparam int SYNC_EN_BIT = 31;
  localparam int CMD_FORCE_BIT = 20;
  localparam int LUT_MULTI_BIT = 11;
  localparam int LUT_ANY_BIT = 10;
  localparam logic [15:0] RST_PERIOD = 16'h0001;
  localparam logic [7:0] RST_BLK_LVL = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================
  // Trigger coding
  localparam int N_CELL = 8;
  localparam int CELL_IN = 8;
  localparam logic [1:0] CODE_SYNC = 2'h3;
  localparam logic [7:0] FORCED_TYPE = 8'h00;
  // ==========================================
  // Timing
  localparam int CLK_NS = 50;
  localparam int BUSY_NS = 3000;
  localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================
  // Types
  typedef struct packed {
    logic multi;
    logic any;
    logic [1:0] code;
    logic [7:0] etype;
  } sett_lut_t;
  typedef struct packed {
    logic valid;
    logic [1:0] code;
    logic [7:0] etype;
    logic [7:0] ptype;
    logic [31:0] evnum;
    logic [31:0] tstamp;
  } sett_trig_t;
  typedef enum logic [1:0] {ST_RUN, ST_SHORT_BUSY, ST_WAIT_FE} sett_state_t;
endpackage

/* design/sett_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - Periodic sync marks last event of Nth block
// - Block level up to 255 events
// - Period and enable held at 0xD4
// - Periodic mark keeps original event type
// - Forced sync is added event, type zero
// - Bit 20 at 0x100 forces sync
// - Front-panel input also forces sync
// - Own busy 3us, triggers blocked after sync
// - Resume only when all boards idle
// - Event number and time continue
// - Word bit11 multiple, bit10 any fired
// - Bits 9:8 trigger code, 7:0 type
// - Eight main and eight partition cells
// - Fully addressed cells, fixed combining logic
// - Inputs 17-24 local, others readout
// - Code 11 means sync plus trigger1
module sett_top
  import sett_pkg::*;
#(
  parameter int N_FE = 16
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] gtp_in,
  input wire logic [31:0] ext_in,
  input wire logic fp_sync_in,
  input wire logic [N_FE-1:0] fe_busy,
  output sett_pkg::sett_trig_t trig_out,
  output logic [7:0] local_trig,
  output logic sync_busy,
  output logic trig_blocked
);
  import sett_pkg::*;

  localparam int CW = $clog2(2 * N_CELL);
  localparam int LW = CW + CELL_IN;

  // ==========================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i+:8] = d[8*i+:8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return a == OFF_SYNC_CTRL || a == OFF_CMD || a == OFF_BLK_LVL || a == OFF_STATUS ||
      a == OFF_LUT_ADDR || a == OFF_LUT_DATA || a == OFF_EVT_NUM || a == OFF_TRG_TIME;
  endfunction

  function automatic logic [3:0] popcnt(input logic [CELL_IN-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < CELL_IN; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // Lowest-numbered firing cell wins the type; not software alterable
  function automatic sett_lut_t combine(input sett_lut_t [N_CELL-1:0] w);
    sett_lut_t r;
    logic [3:0] n;
    r = '0;
    n = 4'h0;
    for (int i = N_CELL - 1; i >= 0; i--) begin
      if (w[i].any) begin
        r.code = w[i].code;
        r.etype = w[i].etype;
        r.multi = r.multi | w[i].multi;
        n = n + 4'h1;
      end
    end
    r.any = n != 4'h0;
    r.multi = r.multi | (n > 4'h1);
    return r;
  endfunction

  // ==========================================
  // Registers and state
  logic [15:0] period_reg;
  logic sync_en_reg;
  logic [7:0] blk_lvl_reg;
  logic [LW-1:0] lut_addr_reg;
  logic [9:0] lut_mem [2**LW];
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  sett_state_t state_reg;
  logic [$clog2(BUSY_CYC+1)-1:0] busy_cnt_reg;
  logic force_pend_reg;
  logic fp_prev_reg;
  logic [7:0] evt_in_blk_reg;
  logic [15:0] blk_cnt_reg;
  logic [31:0] evnum_reg;
  logic [31:0] time_reg;
  sett_trig_t trig_reg;
  logic [7:0] local_reg;

  // ==========================================
  // Bus handshakes
  logic wr_go;
  logic rd_go;
  logic wr_ok;
  logic force_cmd;
  logic [31:0] sc_new;
  logic [31:0] bl_new;
  logic [31:0] la_new;
  logic [31:0] ld_new;
  // Byte-lane merged write values, one per writable register except the command word at 0x100
  assign sc_new = merge({sync_en_reg, 15'h0, period_reg}, s_axi_wdata, s_axi_wstrb);
  assign bl_new = merge({24'h0, blk_lvl_reg}, s_axi_wdata, s_axi_wstrb);
  assign la_new = merge(32'(lut_addr_reg), s_axi_wdata, s_axi_wstrb);
  assign ld_new = merge({22'h0, lut_mem[lut_addr_reg]}, s_axi_wdata, s_axi_wstrb);
  assign wr_go = ce && s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign rd_go = ce && s_axi_arvalid && !rvalid_reg;
  assign wr_ok = wr_go && mapped(s_axi_awaddr);
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign force_cmd = wr_go && s_axi_awaddr == OFF_CMD && s_axi_wstrb[2] && s_axi_wdata[CMD_FORCE_BIT];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      period_reg <= RST_PERIOD;
      sync_en_reg <= 1'b0;
      blk_lvl_reg <= RST_BLK_LVL;
      lut_addr_reg <= '0;
    end else if (ce && wr_ok) begin
      unique case (s_axi_awaddr)
        OFF_SYNC_CTRL: begin
          sync_en_reg <= sc_new[SYNC_EN_BIT];
          period_reg <= sc_new[15:0];
        end
        OFF_BLK_LVL: blk_lvl_reg <= bl_new[7:0];
        OFF_LUT_ADDR: lut_addr_reg <= la_new[LW-1:0];
        default: ;
      endcase
    end
  end

  // Sixteen cells share one flop array; contents are loaded by software
  always_ff @(posedge clock) begin
    if (ce && wr_ok && s_axi_awaddr == OFF_LUT_DATA) begin
      lut_mem[lut_addr_reg] <= ld_new[9:0];
    end
  end

  always_comb begin
    rdata_next = 32'h0;
    unique case (s_axi_araddr)
      OFF_SYNC_CTRL: rdata_next = {sync_en_reg, 15'h0, period_reg};
      OFF_BLK_LVL: rdata_next = {24'h0, blk_lvl_reg};
      OFF_STATUS: rdata_next = {blk_cnt_reg, 8'h0, evt_in_blk_reg[4:0], force_pend_reg,
        state_reg == ST_WAIT_FE, state_reg == ST_SHORT_BUSY};
      OFF_LUT_ADDR: rdata_next = 32'(lut_addr_reg);
      OFF_LUT_DATA: rdata_next = {22'h0, lut_mem[lut_addr_reg]};
      OFF_EVT_NUM: rdata_next = evnum_reg;
      OFF_TRG_TIME: rdata_next = time_reg;
      default: rdata_next = 32'h0;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        rdata_reg <= rdata_next;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // Lookup cells
  logic [31:0] ext_ro;
  sett_lut_t [2*N_CELL-1:0] cell_word;
  sett_lut_t main_w;
  sett_lut_t part_w;
  // Local inputs 17-24 never reach the readout cells
  assign ext_ro = {ext_in[31:24], 8'h00, ext_in[15:0]};

  for (genvar c = 0; c < 2 * N_CELL; c++) begin : g_cell
    logic [CELL_IN-1:0] cin;
    logic [3:0] n;
    logic [9:0] e;
    assign cin = (c % N_CELL) < 4 ? gtp_in[CELL_IN*(c%4)+:CELL_IN] : ext_ro[CELL_IN*(c%4)+:CELL_IN];
    assign n = popcnt(cin);
    assign e = lut_mem[{CW'(c), cin}];
    // Stored code and type below them
    assign cell_word[c] = {n > 4'h1, n != 4'h0, e};
  end

  assign main_w = combine(cell_word[N_CELL-1:0]);
  assign part_w = combine(cell_word[2*N_CELL-1:N_CELL]);

  // ==========================================
  // Event sequencing
  logic fe_any;
  logic run_ok;
  logic accept;
  logic last_in_blk;
  logic last_blk;
  logic mark;
  logic force_go;
  logic sync_issue;
  logic fp_edge;
  assign fe_any = |fe_busy;
  // Blocked by own counter or any outside busy
  assign run_ok = state_reg == ST_RUN && !fe_any;
  assign accept = main_w.any && run_ok;
  assign last_in_blk = evt_in_blk_reg + 8'h1 >= blk_lvl_reg;
  assign last_blk = blk_cnt_reg + 16'h1 >= period_reg;
  // Final event of every Nth block
  assign mark = sync_en_reg && last_in_blk && last_blk;
  // Real triggers take priority; the added event waits for a free cycle
  assign force_go = force_pend_reg && run_ok && !main_w.any;
  assign sync_issue = (accept && mark) || force_go;
  assign fp_edge = fp_sync_in && !fp_prev_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      force_pend_reg <= 1'b0;
      fp_prev_reg <= 1'b0;
    end else if (ce) begin
      fp_prev_reg <= fp_sync_in;
      // Command or panel edge; a new request outlives the clear
      if (force_cmd || fp_edge) begin
        force_pend_reg <= 1'b1;
      end else if (force_go) begin
        force_pend_reg <= 1'b0;
      end
    end
  end

  // Short busy then wait for every board
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_RUN;
      busy_cnt_reg <= '0;
    end else if (ce) begin
      unique case (state_reg)
        ST_RUN: begin
          if (sync_issue) begin
            state_reg <= ST_SHORT_BUSY;
            busy_cnt_reg <= ($bits(busy_cnt_reg))'(BUSY_CYC - 1);
          end
        end
        ST_SHORT_BUSY: begin
          if (busy_cnt_reg == '0) begin
            state_reg <= ST_WAIT_FE;
          end else begin
            busy_cnt_reg <= busy_cnt_reg - 1'b1;
          end
        end
        ST_WAIT_FE: begin
          if (!fe_any) begin
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end

  // Counters never cleared by the pause
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      time_reg <= 32'h0;
      evnum_reg <= 32'h0;
      evt_in_blk_reg <= 8'h0;
      blk_cnt_reg <= 16'h0;
    end else if (ce) begin
      time_reg <= time_reg + 32'h1;
      if (accept || force_go) begin
        evnum_reg <= evnum_reg + 32'h1;
      end
      // Added events are not counted into blocks
      if (accept) begin
        evt_in_blk_reg <= last_in_blk ? 8'h0 : evt_in_blk_reg + 8'h1;
        if (last_in_blk) begin
          blk_cnt_reg <= last_blk ? 16'h0 : blk_cnt_reg + 16'h1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trig_reg <= '0;
      local_reg <= 8'h0;
    end else if (ce) begin
      local_reg <= ext_in[23:16];
      trig_reg.valid <= accept || force_go;
      trig_reg.evnum <= evnum_reg;
      trig_reg.tstamp <= time_reg;
      if (accept) begin
        trig_reg.code <= mark ? CODE_SYNC : main_w.code;
        trig_reg.etype <= main_w.etype;
        trig_reg.ptype <= part_w.etype;
      end else if (force_go) begin
        trig_reg.code <= CODE_SYNC;
        trig_reg.etype <= FORCED_TYPE;
        trig_reg.ptype <= FORCED_TYPE;
      end
    end
  end

  assign trig_out = trig_reg;
  assign local_trig = local_reg;
  assign sync_busy = state_reg == ST_SHORT_BUSY;
  assign trig_blocked = !run_ok;
endmodule

/* tb/sett_chk.sv */
`timescale 1ns/1ps
module sett_chk
  import sett_pkg::*;
#(
  parameter int N_FE = 16
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] ext_in,
  input wire logic [N_FE-1:0] fe_busy,
  input sett_pkg::sett_trig_t trig_out,
  input wire logic [7:0] local_trig,
  input wire logic sync_busy,
  input wire logic trig_blocked
);
  logic [7:0] bcnt_reg;
  logic [31:0] nxt_reg;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // Busy length and expected event number
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bcnt_reg <= 8'h00;
      nxt_reg <= 32'h0;
    end else if (ce) begin
      bcnt_reg <= sync_busy ? bcnt_reg + 8'h01 : 8'h00;
      if (trig_out.valid) nxt_reg <= trig_out.evnum + 32'h1;
    end
  end
  // ==========================================
  // Properties
  chk_busy_len: assert property (!sync_busy && bcnt_reg != 8'h00 |-> bcnt_reg == BUSY_CYC)
    else $error("sync busy length wrong");
  chk_sync_busy: assert property (trig_out.valid && trig_out.code == CODE_SYNC |-> sync_busy)
    else $error("no busy with resync event");
  chk_drop_blk: assert property (ce && trig_blocked |=> !trig_out.valid)
    else $error("event passed while blocked");
  chk_blk_src: assert property (sync_busy || fe_busy != '0 |-> trig_blocked)
    else $error("busy without blocking");
  chk_resume_idle: assert property ($fell(trig_blocked) |-> !sync_busy && fe_busy == '0)
    else $error("resumed while busy");
  chk_evnum_seq: assert property (trig_out.valid |-> trig_out.evnum == nxt_reg)
    else $error("event number gap");
  chk_local_trig: assert property ($past(ce) && $past(arst_n) |-> local_trig == $past(ext_in[23:16]))
    else $error("local trigger mismatch");
  chk_aw_resp: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response missing");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule

bind sett_top sett_chk #(.N_FE(N_FE)) u_chk (.clock, .arst_n, .ce, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bvalid, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ext_in, .fe_busy, .trig_out,
  .local_trig, .sync_busy, .trig_blocked);

/* tb/sett_fe_model.sv */
`timescale 1ns/1ps
module sett_fe_model
  import sett_pkg::*;
#(
  parameter int N_FE = 16
) (
  input wire logic clock,
  input wire logic arst_n,
  input sett_pkg::sett_trig_t trig,
  input wire logic [N_FE-1:0] ack,
  input wire logic [3:0] npend,
  input wire logic [7:0] dly,
  output logic [N_FE-1:0] busy
);
  logic [7:0] cnt_reg;
  logic [3:0] pend_reg [N_FE];
  // ==========================================
  // Board reaction to a resync event
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 8'h00;
      busy <= '0;
      for (int i = 0; i < N_FE; i++) pend_reg[i] <= 4'h0;
    end else begin
      // busy within 3us: delay kept below the short busy
      if (trig.valid && trig.code == CODE_SYNC) cnt_reg <= dly;
      else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
      for (int i = 0; i < N_FE; i++) begin
        if (cnt_reg == 8'h01) begin
          busy[i] <= 1'b1;
          pend_reg[i] <= npend;
        end else if (ack[i] && busy[i]) begin
          pend_reg[i] <= pend_reg[i] - 4'h1;
          if (pend_reg[i] == 4'h1) busy[i] <= 1'b0;
        end
      end
    end
  end
endmodule

/* tb/sett_top_tb_top.sv */
`timescale 1ns/1ps
module sett_top_tb_top;
  import sett_pkg::*;
  logic clock = 1'b0, arst_n = 1'b0, ce = 1'b1, fp_sync_in = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sync_busy, trig_blocked;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, gtp_in = 32'h0, ext_in = 32'h0, rdat, s_axi_rdata;
  logic [1:0] rsp, s_axi_bresp, s_axi_rresp;
  logic [7:0] local_trig, dly = 8'h0A;
  logic [15:0] fe_busy, ack = 16'h0000;
  logic [3:0] npend = 4'h1;
  logic [11:0] la [4] = '{12'h001, 12'h003, 12'h801, 12'h803};
  logic [31:0] ld [4] = '{32'h15A, 32'h2A5, 32'h033, 32'h044};
  sett_trig_t trig_out, last;
  int errors = 0, n_checks = 0, nev = 0;
  always #25 clock = ~clock;
  sett_top #(.N_FE(16)) DUT (.clock, .arst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .gtp_in, .ext_in, .fp_sync_in, .fe_busy, .trig_out, .local_trig,
    .sync_busy, .trig_blocked);
  sett_fe_model #(.N_FE(16)) FE (.clock, .arst_n, .trig(trig_out), .ack, .npend, .dly, .busy(fe_busy));
  always @(posedge clock) begin
    if (trig_out.valid) begin
      last <= trig_out;
      nev <= nev + 1;
    end
  end
  // ==========================================
  // Tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do begin
      @(posedge clock);
      i++;
    end while ((w ? s_axi_awready : s_axi_arready) !== 1'b1 && i < 99);
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && i < 99) begin
      @(posedge clock);
      i++;
    end
    rdat = s_axi_rdata;
    rsp = w ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (i >= 99) begin
      chk(32'h0, 32'h1);
      stop_test;
    end
  endtask
  task fire(input logic [31:0] v);
    @(posedge clock);
    gtp_in <= v;
    @(posedge clock);
    gtp_in <= 32'h0;
  endtask
  task ev(input int n, input logic [1:0] c, input logic [7:0] t, p, input logic [31:0] e);
    for (int i = 0; i < 300 && nev != n; i++) @(posedge clock);
    if (nev != n) begin
      chk(32'h0, 32'h1);
      stop_test;
    end
    chk(last.code, c);
    chk(last.etype, t);
    chk(last.ptype, p);
    chk(last.evnum, e);
  endtask
  // Waits for trig_blocked (b=1) or the short busy (b=0) to clear
  task till(input logic b);
    int i;
    for (i = 0; i < 3000 && (b ? trig_blocked : sync_busy) !== 1'b0; i++) @(posedge clock);
    if (i == 3000) begin
      chk(32'h0, 32'h1);
      stop_test;
    end
  endtask
  task ackp(input logic [15:0] m);
    @(posedge clock);
    ack <= m;
    @(posedge clock);
    ack <= 16'h0000;
    @(posedge clock);
    // Let the edge's register updates settle before the caller compares
    #1;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    bus(1'b0, OFF_SYNC_CTRL, 32'h0); chk(rdat, 32'h1);
    bus(1'b0, OFF_BLK_LVL, 32'h0); chk(rdat, 32'h1);
    bus(1'b0, 12'h004, 32'h0); chk(rsp, RESP_SLVERR);
    bus(1'b1, OFF_SYNC_CTRL, 32'h80000002); chk(rsp, RESP_OKAY);
    bus(1'b0, OFF_SYNC_CTRL, 32'h0); chk(rdat, 32'h80000002);
    bus(1'b1, OFF_BLK_LVL, 32'h2);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, OFF_LUT_ADDR, {20'h0, la[k]});
      bus(1'b1, OFF_LUT_DATA, ld[k]);
    end
    $display("registers done");
    fire(32'h1); ev(1, 2'h1, 8'h5A, 8'h33, 32'd0);
    fire(32'h3); ev(2, 2'h2, 8'hA5, 8'h44, 32'd1);
    fire(32'h1); ev(3, 2'h1, 8'h5A, 8'h33, 32'd2);
    npend <= 4'h2;
    fire(32'h1); ev(4, CODE_SYNC, 8'h5A, 8'h33, 32'd3);
    chk(sync_busy, 1'b1);
    fire(32'h1); chk(nev, 4);
    till(1'b0); chk(trig_blocked, 1'b1);
    ackp(16'hFFFF); chk(trig_blocked, 1'b1);
    ackp(16'h7FFF); chk(trig_blocked, 1'b1);
    ackp(16'h8000); chk(trig_blocked, 1'b0);
    fire(32'h1); ev(5, 2'h1, 8'h5A, 8'h33, 32'd4);
    $display("periodic done");
    dly <= 8'd50;
    npend <= 4'h1;
    bus(1'b1, OFF_CMD, 32'h00100000); ev(6, CODE_SYNC, FORCED_TYPE, 8'h00, 32'd5);
    till(1'b0); ackp(16'hFFFF); till(1'b1);
    repeat (20) @(posedge clock);
    chk(nev, 6);
    bus(1'b0, OFF_CMD, 32'h0); chk(rdat, 32'h0);
    fp_sync_in <= 1'b1;
    repeat (5) @(posedge clock);
    fp_sync_in <= 1'b0;
    ev(7, CODE_SYNC, FORCED_TYPE, 8'h00, 32'd6);
    till(1'b0); ackp(16'hFFFF); till(1'b1);
    $display("forced done");
    ext_in <= 32'h00FF0000;
    repeat (2) @(posedge clock);
    chk(local_trig, 8'hFF);
    ext_in <= 32'h0;
    repeat (3) @(posedge clock);
    chk(nev, 7);
    $display("local done");
    stop_test;
  end
endmodule
